/* File: hdl/ir_carrier_irq_dma_config.sv */
// Purpose: APB register bank setting infrared carriers, prescaler, interrupt and DMA routing
// Assumes: refTick, irqEvent, rxActive and DMA requests come from logic on clock; dack pins are async
// Notes: zero-wait APB slave, read data is captured in the setup cycle
`timescale 1ns/1ps

// Summary of operation
// [R1] low receive range: centre codes 0-7 give 25 to 60 kHz in 5 kHz steps
// [R2] high receive range: centre codes 0,1,2 give 400, 450, 480 kHz
// [R3] demod register holds delta in bits 5-4, centre in 3-0, reset zero
// [R4] low transmit range: codes 0 to 26 give 30 to 56 kHz, others invalid
// [R5] high transmit range: codes 0-3 give 400/450/480/500 kHz; width bits 7-5
// [R6] pulse width codes 0-3 give 6.0-10.6 us low, 0.7-1.0 us high
// [R7] prescaler divides the 48 MHz tick by the 6-bit value
// [R8] divisors 1 to 63 supported; value zero gives no output clock
// [R9] prescaler value resets to hex 1A
// [R10] interrupt channel codes 1-11 route to lines 3-7,9-12,14,15; others none
// [R11] interrupt bits 5-4 give status FIFO threshold 1, 4, 7 or 8
// [R12] interrupt bit 6: zero open-drain, one totem-pole
// [R13] totem-pole bit 7 selects active low; ignored in open-drain
// [R14] DMA bits 2-0 choose transmit pair 0, 1 or 3 one-hot
// [R15] DMA bits 5-3 choose receive pair with the same coding
// [R16] both directions on one pair: that pair's output goes high impedance
// [R17] host gives separate pairs in UART use, may share in infrared
// [R18] DMA bit 6 enables requests on the selected pair, resets zero
// [R19] writing one to DMA bit 7 resets the status FIFO, self clearing
// [R20] carrier bit 4 selects receive range low or high
// [R21] carrier bit 2 selects transmit range low or high
// [R22] DMA select codes other than one-hot leave that direction with no pair
module ir_carrier_irq_dma_config #(
  parameter int PRESC_WIDTH = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxActive,
  input wire logic refTick,
  output logic prescTick,
  output ir_cfg_pkg::rx_carrier_t rxCarrier,
  output ir_cfg_pkg::tx_carrier_t txCarrier,
  output logic [1:0] modulationMode,
  output logic statusFifoReset,
  output logic [3:0] statusThreshold,
  input wire logic irqEvent,
  output logic [ir_cfg_pkg::IRQ_LINES-1:0] irqOut,
  output logic [ir_cfg_pkg::IRQ_LINES-1:0] irqOe_n,
  input wire logic txDmaReq,
  input wire logic rxDmaReq,
  output logic [ir_cfg_pkg::DMA_PAIRS-1:0] drqOut,
  output logic [ir_cfg_pkg::DMA_PAIRS-1:0] drqOe_n,
  input wire logic [ir_cfg_pkg::DMA_PAIRS-1:0] dackIn_n,
  output logic txDack,
  output logic rxDack
);

  // ******
  // bus decode
  // ******
  logic [6:0] carrierCfg_reg;
  logic [5:0] rxDemod_reg;
  logic [7:0] txMod_reg;
  logic [PRESC_WIDTH-1:0] presc_reg;
  logic [7:0] irqCfg_reg;
  logic [6:0] dmaSel_reg;
  logic fifoReset_reg;
  logic [7:0] regIdx;
  logic mapped;
  logic wrEn;
  logic [31:0] readData;
  logic [31:0] routingStatus;
  assign regIdx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (regIdx inside {ir_cfg_pkg::CARRIER_CONFIG_IDX, ir_cfg_pkg::RX_DEMOD_CONFIG_IDX,
                   ir_cfg_pkg::TX_MOD_CONFIG_IDX, ir_cfg_pkg::CLOCK_PRESCALER_IDX, ir_cfg_pkg::INTERRUPT_CONFIG_IDX,
                   ir_cfg_pkg::DMA_CHANNEL_SELECT_IDX, ir_cfg_pkg::ROUTING_STATUS_IDX});
  assign wrEn = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ******
  // registers
  // ******
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      carrierCfg_reg <= ir_cfg_pkg::CARRIER_CONFIG_RST;
      rxDemod_reg <= ir_cfg_pkg::RX_DEMOD_CONFIG_RST; // [R3]
      txMod_reg <= ir_cfg_pkg::TX_MOD_CONFIG_RST;
      presc_reg <= PRESC_WIDTH'(ir_cfg_pkg::CLOCK_PRESCALER_RST); // [R9]
      irqCfg_reg <= ir_cfg_pkg::INTERRUPT_CONFIG_RST;
      dmaSel_reg <= ir_cfg_pkg::DMA_CHANNEL_SELECT_RST;
    end else if (wrEn) begin
      case (regIdx)
        ir_cfg_pkg::CARRIER_CONFIG_IDX: carrierCfg_reg <= pwdata[6:0];
        ir_cfg_pkg::RX_DEMOD_CONFIG_IDX: rxDemod_reg <= pwdata[5:0]; // [R3]
        ir_cfg_pkg::TX_MOD_CONFIG_IDX: txMod_reg <= pwdata[7:0]; // [R5]
        ir_cfg_pkg::CLOCK_PRESCALER_IDX: presc_reg <= pwdata[PRESC_WIDTH-1:0]; // [R7]
        ir_cfg_pkg::INTERRUPT_CONFIG_IDX: irqCfg_reg <= pwdata[7:0];
        ir_cfg_pkg::DMA_CHANNEL_SELECT_IDX: dmaSel_reg <= pwdata[6:0]; // [R18]
        default: ;
      endcase
    end
  end
  // one-cycle pulse; the bit never stores, so it reads back zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifoReset_reg <= 1'b0;
    end else begin
      fifoReset_reg <= wrEn && (regIdx == ir_cfg_pkg::DMA_CHANNEL_SELECT_IDX) &&
                       pwdata[ir_cfg_pkg::FIFO_RESET_BIT]; // [R19]
    end
  end
  assign statusFifoReset = fifoReset_reg;
  // interrupt and DMA selects are write only and read as zero
  always_comb begin
    readData = 32'h0000_0000;
    case (regIdx)
      ir_cfg_pkg::CARRIER_CONFIG_IDX: readData = {24'h00_0000, rxActive, carrierCfg_reg};
      ir_cfg_pkg::RX_DEMOD_CONFIG_IDX: readData = {26'h000_0000, rxDemod_reg};
      ir_cfg_pkg::TX_MOD_CONFIG_IDX: readData = {24'h00_0000, txMod_reg};
      ir_cfg_pkg::CLOCK_PRESCALER_IDX: readData = {{(32-PRESC_WIDTH){1'b0}}, presc_reg};
      ir_cfg_pkg::ROUTING_STATUS_IDX: readData = routingStatus;
      default: readData = 32'h0000_0000;
    endcase
  end
  // captured in setup so access data comes from a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= (mapped && !pwrite) ? readData : 32'h0000_0000;
    end
  end

  // ******
  // receive demodulation lookup
  // ******
  function automatic logic [7:0] lowDelta(input logic [2:0] c, input logic [1:0] d);
    logic [7:0] r;
    r = 8'd2;
    case (d)
      2'h0: r = 8'd2;
      2'h1: r = (c < 3'h2) ? 8'd4 : (c < 3'h4) ? 8'd5 : (c < 3'h7) ? 8'd8 : 8'd10;
      2'h2: r = (c < 3'h2) ? 8'd6 : (c == 3'h2) ? 8'd8 : (c == 3'h3) ? 8'd10 : 8'd15;
      default: r = (c == 3'h0) ? 8'd8 : (c < 3'h3) ? 8'd10 : (c == 3'h3) ? 8'd15 : (c < 3'h7) ? 8'd20 : 8'd25;
    endcase
    return r;
  endfunction
  function automatic logic [7:0] highDelta(input logic [1:0] c, input logic [1:0] d);
    logic [7:0] r;
    r = 8'd20;
    case (d)
      2'h0: r = 8'd20;
      2'h1: r = 8'd50;
      2'h2: r = (c == 2'h2) ? 8'd120 : 8'd100;
      default: r = (c == 2'h2) ? 8'd200 : 8'd150;
    endcase
    return r;
  endfunction
  logic rxHigh;
  logic [3:0] centreCode;
  logic [1:0] deltaCode;
  assign rxHigh = carrierCfg_reg[ir_cfg_pkg::RX_RANGE_BIT]; // [R20]
  assign centreCode = rxDemod_reg[3:0];
  assign deltaCode = rxDemod_reg[5:4];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxCarrier <= '0;
    end else if (rxHigh) begin
      rxCarrier.valid <= centreCode < 4'h3; // [R2]
      rxCarrier.centreKhz <= (centreCode == 4'h0) ? 10'd400 : (centreCode == 4'h1) ? 10'd450 : 10'd480;
      rxCarrier.deltaKhz <= highDelta(centreCode[1:0], deltaCode); // [R3]
    end else begin
      rxCarrier.valid <= centreCode < 4'h8; // [R1]
      rxCarrier.centreKhz <= 10'd25 + 10'(centreCode[2:0]) * 10'd5; // [R1]
      rxCarrier.deltaKhz <= lowDelta(centreCode[2:0], deltaCode); // [R3]
    end
  end

  // ******
  // transmit modulation lookup
  // ******
  logic txHigh;
  logic [4:0] freqCode;
  logic [2:0] widthCode;
  assign txHigh = carrierCfg_reg[ir_cfg_pkg::TX_RANGE_BIT]; // [R21]
  assign freqCode = txMod_reg[4:0]; // [R5]
  assign widthCode = txMod_reg[7:5]; // [R5]
  assign modulationMode = carrierCfg_reg[1:0];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txCarrier <= '0;
    end else if (txHigh) begin
      txCarrier.freqValid <= freqCode < 5'h04; // [R5]
      case (freqCode[1:0])
        2'h0: txCarrier.freqKhz <= 10'd400;
        2'h1: txCarrier.freqKhz <= 10'd450;
        2'h2: txCarrier.freqKhz <= 10'd480;
        default: txCarrier.freqKhz <= 10'd500;
      endcase
      txCarrier.widthValid <= widthCode < 3'h4; // [R6]
      txCarrier.widthNs <= 14'd700 + 14'(widthCode[1:0]) * 14'd100; // [R6]
    end else begin
      txCarrier.freqValid <= freqCode <= 5'h1A; // [R4]
      txCarrier.freqKhz <= 10'd30 + 10'(freqCode); // [R4]
      txCarrier.widthValid <= widthCode < 3'h4; // [R6]
      case (widthCode[1:0])
        2'h0: txCarrier.widthNs <= 14'd6000; // [R6]
        2'h1: txCarrier.widthNs <= 14'd7000;
        2'h2: txCarrier.widthNs <= 14'd9000;
        default: txCarrier.widthNs <= 14'd10600;
      endcase
    end
  end

  // ******
  // prescaler
  // ******
  logic [PRESC_WIDTH-1:0] prescCount_reg;
  logic prescTick_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prescCount_reg <= '0;
      prescTick_reg <= 1'b0;
    end else if (presc_reg == '0) begin
      prescCount_reg <= '0;
      prescTick_reg <= 1'b0; // [R8]
    end else if (refTick) begin
      if (prescCount_reg + PRESC_WIDTH'(1) >= presc_reg) begin
        prescCount_reg <= '0;
        prescTick_reg <= 1'b1; // [R7]
      end else begin
        prescCount_reg <= prescCount_reg + PRESC_WIDTH'(1);
        prescTick_reg <= 1'b0;
      end
    end else begin
      prescTick_reg <= 1'b0;
    end
  end
  assign prescTick = prescTick_reg;

  // ******
  // interrupt routing
  // ******
  ir_cfg_pkg::irq_route_t irqRoute;
  always_comb begin
    irqRoute.totemPole = irqCfg_reg[ir_cfg_pkg::IRQ_MODE_BIT]; // [R12]
    irqRoute.activeLow = irqCfg_reg[ir_cfg_pkg::IRQ_POLARITY_BIT]; // [R13]
    case (irqCfg_reg[5:4])
      2'h0: irqRoute.threshold = 4'd1; // [R11]
      2'h1: irqRoute.threshold = 4'd4;
      2'h2: irqRoute.threshold = 4'd7;
      default: irqRoute.threshold = 4'd8;
    endcase
    case (irqCfg_reg[3:0])
      4'h1: irqRoute.line = 5'd3; // [R10]
      4'h2: irqRoute.line = 5'd4;
      4'h3: irqRoute.line = 5'd5;
      4'h4: irqRoute.line = 5'd6;
      4'h5: irqRoute.line = 5'd7;
      4'h6: irqRoute.line = 5'd9;
      4'h7: irqRoute.line = 5'd10;
      4'h8: irqRoute.line = 5'd11;
      4'h9: irqRoute.line = 5'd12;
      4'hA: irqRoute.line = 5'd14;
      4'hB: irqRoute.line = 5'd15;
      default: irqRoute.line = 5'h1F; // no line
    endcase
  end
  assign statusThreshold = irqRoute.threshold;
  genvar gi;
  generate
    for (gi = 0; gi < ir_cfg_pkg::IRQ_LINES; gi = gi + 1) begin : irqPin
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          irqOut[gi] <= 1'b0;
          irqOe_n[gi] <= 1'b1;
        end else if (irqRoute.line != 5'(gi)) begin
          irqOut[gi] <= 1'b0;
          irqOe_n[gi] <= 1'b1; // [R10]
        end else if (irqRoute.totemPole) begin
          irqOut[gi] <= irqEvent ^ irqRoute.activeLow; // [R13]
          irqOe_n[gi] <= 1'b0; // [R12]
        end else begin
          // open-drain pulls low only during the event; polarity is ignored
          irqOut[gi] <= 1'b0;
          irqOe_n[gi] <= !irqEvent; // [R12] [R13]
        end
      end
    end
  endgenerate

  // ******
  // DMA routing
  // ******
  logic [2:0] txSel;
  logic [2:0] rxSel;
  logic txSelOk;
  logic rxSelOk;
  logic dmaEnable;
  logic [ir_cfg_pkg::DMA_PAIRS-1:0] dackMeta_reg;
  logic [ir_cfg_pkg::DMA_PAIRS-1:0] dackSync_reg;
  logic [ir_cfg_pkg::DMA_PAIRS-1:0] txOwn;
  logic [ir_cfg_pkg::DMA_PAIRS-1:0] rxOwn;
  assign txSel = dmaSel_reg[2:0]; // [R14]
  assign rxSel = dmaSel_reg[5:3]; // [R15]
  assign dmaEnable = dmaSel_reg[ir_cfg_pkg::DMA_ENABLE_BIT]; // [R18]
  assign txSelOk = $onehot(txSel); // [R22]
  assign rxSelOk = $onehot(rxSel); // [R22]
  // acknowledge pins are asynchronous to clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dackMeta_reg <= '1;
      dackSync_reg <= '1;
    end else begin
      dackMeta_reg <= dackIn_n;
      dackSync_reg <= dackMeta_reg;
    end
  end
  generate
    for (gi = 0; gi < ir_cfg_pkg::DMA_PAIRS; gi = gi + 1) begin : dmaPair
      assign txOwn[gi] = txSelOk && txSel[gi]; // [R14] [R22]
      assign rxOwn[gi] = rxSelOk && rxSel[gi]; // [R15] [R22]
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          drqOut[gi] <= 1'b0;
          drqOe_n[gi] <= 1'b1;
        end else if (txOwn[gi] && rxOwn[gi]) begin
          // a shared pair is released rather than fought over
          drqOut[gi] <= 1'b0;
          drqOe_n[gi] <= 1'b1; // [R16] [R17]
        end else if (txOwn[gi] || rxOwn[gi]) begin
          drqOut[gi] <= dmaEnable && (txOwn[gi] ? txDmaReq : rxDmaReq); // [R18]
          drqOe_n[gi] <= 1'b0;
        end else begin
          drqOut[gi] <= 1'b0;
          drqOe_n[gi] <= 1'b1; // [R22]
        end
      end
    end
  endgenerate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txDack <= 1'b0;
      rxDack <= 1'b0;
    end else begin
      txDack <= |(txOwn & ~rxOwn & ~dackSync_reg); // [R16] [R22]
      rxDack <= |(rxOwn & ~txOwn & ~dackSync_reg); // [R16] [R22]
    end
  end

  // ******
  // routing status readback
  // ******
  assign routingStatus = {12'h000, |(txOwn & rxOwn), rxSelOk, txSelOk, irqRoute.line, rxCarrier.valid,
                          txCarrier.freqValid, txCarrier.widthValid, presc_reg != '0, irqRoute.threshold,
                          irqRoute.totemPole, irqRoute.activeLow, dmaEnable, rxActive};
endmodule

/* File: hdl/ir_cfg_pkg.sv */
// Purpose: constants and carriers for the infrared carrier, interrupt and DMA configuration bank
// Assumes: register index = bank * 16 + printed offset, byte address = index * 4
// Notes: all reset values, offsets and single-bit field positions live here
package ir_cfg_pkg;

  // ******
  // register indices (byte address is four times these)
  // ******
  localparam logic [7:0] BANK1_BASE = 8'h10;
  localparam logic [7:0] BANK2_BASE = 8'h20;
  localparam logic [7:0] CARRIER_CONFIG_OFS = 8'h0A;
  localparam logic [7:0] RX_DEMOD_CONFIG_OFS = 8'h0B;
  localparam logic [7:0] TX_MOD_CONFIG_OFS = 8'h0C;
  localparam logic [7:0] CLOCK_PRESCALER_OFS = 8'h0A;
  localparam logic [7:0] INTERRUPT_CONFIG_OFS = 8'h0B;
  localparam logic [7:0] DMA_CHANNEL_SELECT_OFS = 8'h0C;
  localparam logic [7:0] CARRIER_CONFIG_IDX = BANK1_BASE + CARRIER_CONFIG_OFS;
  localparam logic [7:0] RX_DEMOD_CONFIG_IDX = BANK1_BASE + RX_DEMOD_CONFIG_OFS;
  localparam logic [7:0] TX_MOD_CONFIG_IDX = BANK1_BASE + TX_MOD_CONFIG_OFS;
  localparam logic [7:0] CLOCK_PRESCALER_IDX = BANK2_BASE + CLOCK_PRESCALER_OFS;
  localparam logic [7:0] INTERRUPT_CONFIG_IDX = BANK2_BASE + INTERRUPT_CONFIG_OFS;
  localparam logic [7:0] DMA_CHANNEL_SELECT_IDX = BANK2_BASE + DMA_CHANNEL_SELECT_OFS;
  localparam logic [7:0] ROUTING_STATUS_IDX = 8'h40;

  // ******
  // reset values
  // ******
  localparam logic [6:0] CARRIER_CONFIG_RST = 7'h00;
  localparam logic [5:0] RX_DEMOD_CONFIG_RST = 6'h00;
  localparam logic [7:0] TX_MOD_CONFIG_RST = 8'h00;
  localparam logic [5:0] CLOCK_PRESCALER_RST = 6'h1A;
  localparam logic [7:0] INTERRUPT_CONFIG_RST = 8'h01;
  localparam logic [6:0] DMA_CHANNEL_SELECT_RST = 7'h00;

  // ******
  // field positions
  // ******
  localparam int RX_RANGE_BIT = 4;
  localparam int TX_RANGE_BIT = 2;
  localparam int DMA_ENABLE_BIT = 6;
  localparam int FIFO_RESET_BIT = 7;
  localparam int IRQ_MODE_BIT = 6;
  localparam int IRQ_POLARITY_BIT = 7;
  localparam int IRQ_LINES = 16;
  localparam int DMA_PAIRS = 3;

  // one-hot pair select codes
  localparam logic [2:0] DMA_SEL_PAIR0 = 3'h1;
  localparam logic [2:0] DMA_SEL_PAIR1 = 3'h2;
  localparam logic [2:0] DMA_SEL_PAIR3 = 3'h4;

  // ******
  // carriers
  // ******
  typedef struct packed {
    logic valid;
    logic [9:0] centreKhz;
    logic [7:0] deltaKhz;
  } rx_carrier_t;

  typedef struct packed {
    logic freqValid;
    logic [9:0] freqKhz;
    logic widthValid;
    logic [13:0] widthNs;
  } tx_carrier_t;

  typedef struct packed {
    logic [3:0] threshold;
    logic totemPole;
    logic activeLow;
    logic [4:0] line;
  } irq_route_t;

endpackage

/* File: testbench/ir_cfg_chk.sv */
// Purpose: port-level checker for the carrier, interrupt and DMA configuration bank
// Assumes: mirrors interrupt and DMA select writes; outputs lag their cause by one edge
// Notes: bound from tb_top
`timescale 1ns/1ps
module ir_cfg_chk #(
  parameter int PRESC_WIDTH = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic refTick,
  input wire logic prescTick,
  input wire logic statusFifoReset,
  input wire logic irqEvent,
  input wire logic [15:0] irqOut,
  input wire logic [15:0] irqOe_n,
  input wire logic txDmaReq,
  input wire logic [2:0] drqOut,
  input wire logic [2:0] drqOe_n
);
  localparam logic [4:0] LNMAP [16] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A,
    5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [7:0] intCfgReg;
  logic [6:0] dmaSelReg;
  logic [4:0] ln;
  logic [2:0] txS;
  logic [2:0] rxS;
  logic wrEdge;
  assign wrEdge = psel & penable & pwrite;
  assign ln = LNMAP[intCfgReg[3:0]];
  assign txS = dmaSelReg[2:0];
  assign rxS = dmaSelReg[5:3];
  // ******
  // shadow copies, updated on the same edge as the bank
  // ******
  always_ff @(posedge clock or posedge rst) begin
    if (rst) intCfgReg <= ir_cfg_pkg::INTERRUPT_CONFIG_RST;
    else if (wrEdge && paddr == 12'h0AC) intCfgReg <= pwdata[7:0];
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) dmaSelReg <= ir_cfg_pkg::DMA_CHANNEL_SELECT_RST;
    else if (wrEdge && paddr == 12'h0B0) dmaSelReg <= pwdata[6:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_irq_line_map: assert property ($past(ln) != 5'h00 && $past(intCfgReg[6]) |->
    irqOe_n == 16'(~(16'h0001 << $past(ln)))) else $error("irq line enable wrong");
  a_irq_none: assert property ($past(ln) == 5'h00 |-> irqOe_n == 16'hFFFF)
    else $error("irq driven with no channel");
  a_totem_level: assert property ($past(ln) != 5'h00 && $past(intCfgReg[6]) |->
    irqOut[$past(ln)] == ($past(irqEvent) ^ $past(intCfgReg[7]))) else $error("totem level wrong");
  a_open_drain: assert property ($past(ln) != 5'h00 && !$past(intCfgReg[6]) |->
    irqOut == 16'h0000 && irqOe_n[$past(ln)] == !$past(irqEvent)) else $error("open drain wrong");
  a_fifo_pulse: assert property (wrEdge && paddr == 12'h0B0 && pwdata[7] |=>
    statusFifoReset ##1 !statusFifoReset) else $error("fifo reset pulse wrong");
  a_fifo_cause: assert property (statusFifoReset |->
    $past(wrEdge && paddr == 12'h0B0 && pwdata[7])) else $error("spurious fifo reset");
  a_tick_cause: assert property (prescTick |-> $past(refTick)) else $error("tick without ref");
  a_dma_shared: assert property ($past(txS == rxS && $onehot(txS)) |->
    drqOe_n[$past(txS >> 1)]) else $error("shared pair driven");
  a_dma_unused: assert property (!$past($onehot(txS)) && !$past($onehot(rxS)) |->
    drqOe_n == 3'h7) else $error("unused pair driven");
  a_dma_tx_drive: assert property ($past($onehot(txS) && txS != rxS) |->
    !drqOe_n[$past(txS >> 1)] && drqOut[$past(txS >> 1)] == $past(dmaSelReg[6] & txDmaReq))
    else $error("tx request wrong");
  c_fifo: cover property (statusFifoReset);
  c_tick: cover property (prescTick);
  c_err: cover property (pslverr);
  c_drq: cover property (drqOe_n != 3'h7);
endmodule

/* File: testbench/dma_host_model.sv */
// Purpose: host side of the interrupt and DMA pins
// Assumes: interrupt lines pulled up, DMA request lines pulled down when released
// Notes: slow adds one cycle to every acknowledge
`timescale 1ns/1ps
module dma_host_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic [15:0] irqOut,
  input wire logic [15:0] irqOe_n,
  input wire logic [2:0] drqOut,
  input wire logic [2:0] drqOe_n,
  output logic [15:0] irqPin,
  output logic [2:0] dackIn_n
);
  logic [2:0] drqPin;
  logic [2:0] ackDly;
  assign irqPin = (~irqOe_n & irqOut) | irqOe_n; // pull-up wins when released
  assign drqPin = ~drqOe_n & drqOut; // high impedance reads low
  initial dackIn_n = 3'h7;
  initial ackDly = 3'h7;
  // acknowledge follows the request on the resolved pin only
  always @(posedge clock) begin
    ackDly <= ~drqPin;
    dackIn_n <= slow ? ackDly : ~drqPin;
  end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the configuration bank
// Assumes: zero-wait APB slave, decoded outputs one edge after the write edge
// Notes: refTick pulses every second cycle, so a divide by N gives a gap of 2N
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] CARRIER_A = 12'h068;
  localparam logic [11:0] RXDEMOD_A = 12'h06C;
  localparam logic [11:0] TXMOD_A = 12'h070;
  localparam logic [11:0] PRESCALER_A = 12'h0A8;
  localparam logic [11:0] INTCFG_A = 12'h0AC;
  localparam logic [11:0] DMASEL_A = 12'h0B0;
  localparam int LN [12] = '{0, 3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
  logic clock, rst, psel, penable, pwrite, rxActive, refTick, irqEvent, txDmaReq, rxDmaReq, slow, rndEv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, errv, prescTick, statusFifoReset, txDack, rxDack, h;
  ir_cfg_pkg::rx_carrier_t rxCarrier;
  ir_cfg_pkg::tx_carrier_t txCarrier;
  logic [3:0] statusThreshold;
  logic [15:0] irqOut, irqOe_n, irqPin;
  logic [2:0] drqOut, drqOe_n, dackIn_n;
  int seed = 32'h2BE1;
  int mismatches = 0;
  int testsRun = 0;
  int k, c, w, n;
  ir_carrier_irq_dma_config dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxActive, .refTick, .prescTick, .rxCarrier, .txCarrier, .modulationMode(),
    .statusFifoReset, .statusThreshold, .irqEvent, .irqOut, .irqOe_n, .txDmaReq, .rxDmaReq, .drqOut,
    .drqOe_n, .dackIn_n, .txDack, .rxDack);
  dma_host_model host (.clock, .slow, .irqOut, .irqOe_n, .drqOut, .drqOe_n, .irqPin, .dackIn_n);
  // ******
  // helpers
  // ******
  function automatic int fq(input logic hi, input int cd);
    if (hi) return cd > 3 ? 0 : cd == 3 ? 500 : cd == 2 ? 480 : cd == 1 ? 450 : 400;
    return cd < 27 ? 30 + cd : 0;
  endfunction
  function automatic int wd(input logic hi, input int cd);
    if (cd > 3) return 0;
    if (hi) return 700 + 100 * cd;
    return cd == 3 ? 10600 : cd == 2 ? 9000 : 6000 + 1000 * cd;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    testsRun++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask
  // request held until pready is seen high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    @(posedge clock);
    @(negedge clock);
  endtask
  task complete_run;
    if (mismatches == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    refTick <= ~refTick;
    if (rndEv) irqEvent <= 1'($random(seed));
  end
  initial begin
    repeat (50000) @(posedge clock);
    mismatches++;
    complete_run();
  end
  // ******
  // main sequence
  // ******
  initial begin
    {psel, penable, pwrite, rxActive, refTick, irqEvent, txDmaReq, rxDmaReq, slow, rndEv} = 10'h000;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(0, PRESCALER_A, 8'h00);
    chk("prescaler reset", rdv, 32'h1A);
    apb(0, RXDEMOD_A, 8'h00);
    chk("demod reset", rdv, 32'h00);
    chk("reset centre", rxCarrier.centreKhz, 25);
    for (k = 0; k < 11; k++) begin
      h = k > 7;
      apb(1, CARRIER_A, {3'h0, h, 4'h0});
      apb(1, RXDEMOD_A, 8'(h ? k - 8 : k));
      settle();
      chk("centre", rxCarrier.centreKhz, h ? (k == 8 ? 400 : k == 9 ? 450 : 480) : 25 + 5 * k);
      chk("delta", rxCarrier.deltaKhz, h ? 20 : 2);
    end
    apb(1, RXDEMOD_A, 8'h22);
    settle();
    chk("high delta", rxCarrier.deltaKhz, 120);
    apb(1, RXDEMOD_A, 8'hFF);
    apb(0, RXDEMOD_A, 8'h00);
    chk("demod readback", rdv, 32'h3F);
    for (k = 0; k < 40; k++) begin
      h = k >= 20;
      c = (k % 20 == 0) ? (h ? 3 : 26) : (k % 20 == 1) ? (h ? 4 : 27) : $random(seed) & (h ? 7 : 31);
      w = $random(seed) & 7;
      apb(1, CARRIER_A, {5'h00, h, 2'h0});
      apb(1, TXMOD_A, 8'(w * 32 + c));
      settle();
      chk("freq ok", txCarrier.freqValid, fq(h, c) != 0);
      if (fq(h, c) != 0) chk("freq", txCarrier.freqKhz, fq(h, c));
      chk("width ok", txCarrier.widthValid, wd(h, w) != 0);
      if (wd(h, w) != 0) chk("width", txCarrier.widthNs, wd(h, w));
    end
    for (k = 0; k < 4; k++) begin
      n = k == 0 ? 0 : k == 1 ? 1 : k == 2 ? 31 : 2 + ($random(seed) & 31);
      apb(1, PRESCALER_A, 8'(n));
      @(negedge clock);
      c = 0;
      w = 0;
      while (prescTick !== 1'b1 && c < 200) begin
        @(negedge clock);
        c++;
      end
      do begin
        @(negedge clock);
        w++;
      end while (prescTick !== 1'b1 && w < 200);
      chk("tick gap", w, n == 0 ? 200 : 2 * n);
    end
    for (k = 0; k < 4; k++) begin
      apb(1, INTCFG_A, 8'(k * 16 + 1));
      settle();
      chk("threshold", statusThreshold, k == 3 ? 8 : 3 * k + 1);
    end
    @(posedge clock);
    {irqEvent, rxActive} <= 2'h3;
    for (k = 0; k < 16; k++) begin
      apb(1, INTCFG_A, 8'(64 + k));
      settle();
      chk("irq enables", irqOe_n, (k > 0 && k < 12) ? 16'(~(16'h0001 << LN[k])) : 16'hFFFF);
    end
    apb(1, INTCFG_A, 8'hC1);
    settle();
    chk("active low", irqPin[3], 1'b0);
    apb(1, INTCFG_A, 8'h81);
    settle();
    chk("open drain pull", irqPin[3], 1'b0);
    @(posedge clock);
    irqEvent <= 1'b0;
    settle();
    chk("open drain release", irqOe_n[3], 1'b1);
    rndEv <= 1'b1;
    // random events under each drive style keep the checker busy
    for (k = 0; k < 3; k++) begin
      apb(1, INTCFG_A, k == 0 ? 8'h05 : k == 1 ? 8'h45 : 8'hC5);
      repeat (50) @(posedge clock);
    end
    rndEv <= 1'b0;
    apb(0, CARRIER_A, 8'h00);
    chk("carrier readback", rdv, 32'h84);
    apb(1, DMASEL_A, 8'h51); // separate pairs for each direction
    settle();
    chk("pair enables", drqOe_n, 3'h4);
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      slow <= k[0];
      txDmaReq <= 1'b1;
      c = 0;
      while (txDack !== 1'b1 && c < 30) begin
        @(negedge clock);
        c++;
      end
      chk("tx ack", txDack, 1'b1);
      @(posedge clock);
      txDmaReq <= 1'b0;
      repeat (12) @(posedge clock);
    end
    apb(1, DMASEL_A, 8'h4C);
    @(posedge clock);
    rxDmaReq <= 1'b1;
    c = 0;
    while (rxDack !== 1'b1 && c < 30) begin
      @(negedge clock);
      c++;
    end
    chk("rx ack", rxDack, 1'b1);
    apb(1, DMASEL_A, 8'h0C);
    settle();
    chk("disabled level", drqOut, 3'h0);
    apb(1, DMASEL_A, 8'h52);
    settle();
    chk("shared pair", drqOe_n, 3'h7);
    apb(1, DMASEL_A, 8'h5B);
    settle();
    chk("unused codes", drqOe_n, 3'h7);
    apb(1, DMASEL_A, 8'h80);
    @(negedge clock);
    chk("fifo reset", statusFifoReset, 1'b1);
    @(negedge clock);
    chk("fifo reset clear", statusFifoReset, 1'b0);
    apb(0, DMASEL_A, 8'h00);
    chk("write only read", rdv, 32'h00);
    apb(0, 12'h0FC, 8'h00);
    chk("unmapped error", errv, 1'b1);
    apb(0, 12'h069, 8'h00);
    chk("misaligned error", errv, 1'b1);
    complete_run();
  end
endmodule
bind ir_carrier_irq_dma_config ir_cfg_chk #(.PRESC_WIDTH(PRESC_WIDTH)) chk_i (.clock, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pslverr, .refTick, .prescTick, .statusFifoReset, .irqEvent, .irqOut, .irqOe_n,
  .txDmaReq, .drqOut, .drqOe_n);
